// file: design/dss_stop_sequencer.sv
// Drive stop mode sequencer with APB configuration registers
`timescale 1ns/100ps
`include "dss_defines.svh"

module dss_stop_sequencer #(
  parameter int unsigned TICK_CYCLES = `DSS_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        runCmd,
  input  wire logic        hwEnable,
  input  wire logic        tripActive,
  input  wire logic        zeroFrequency,
  input  wire logic        lowSpeedSensed,
  input  wire logic        standstill,
  input  wire logic        orientDone,
  output logic             inverterEnable,
  output logic             rampDown,
  output logic             stopNoRamp,
  output logic             lowFreqInject,
  output logic             dcInject,
  output logic [10:0]      injectionLevel,
  output logic             heldStop,
  output logic             driveReady,
  output logic             lockoutActive,
  output logic             orientActive
);
  import dss_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic addrHit(input logic [11:0] a);
    unique case (a)
      `DSS_ADDR_CTRL, `DSS_ADDR_LEVEL,
      `DSS_ADDR_TIME, `DSS_ADDR_STATUS: addrHit = 1'b1;
      default:                          addrHit = 1'b0;
    endcase
  endfunction : addrHit

  function automatic logic invOn(input dss_state_e st);
    unique case (st)
      DSS_READY, DSS_LOCKOUT: invOn = 1'b0;
      default:                invOn = 1'b1;
    endcase
  endfunction : invOn

  localparam dss_regs_s RESET_S = '{
    st:       DSS_READY,
    stopMode: `DSS_MODE_RST,
    swEnable: `DSS_SWEN_RST,
    injLevel: `DSS_LEVEL_RST,
    injTime:  `DSS_TIME_RST,
    driveReady: 1'b1,
    default:  '0
  };

  dss_regs_s s;
  dss_regs_s next_s;

  logic       tickHit;
  logic       timerDone;
  logic       enabled;
  logic       setup;
  logic       access;
  dss_state_e doneSt;
  logic [31:0] ctrlWord;
  logic [31:0] statWord;

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s    = s;
    tickHit   = (s.tick == TICK_CYCLES - 1);
    timerDone = (s.timer == 8'h00);
    enabled   = hwEnable & s.swEnable;
    setup     = psel & ~penable;
    access    = psel & penable & s.pready;
    doneSt    = s.holdZero ? DSS_HELD : DSS_READY;

    ctrlWord = '0;
    ctrlWord[`DSS_CTRL_MODE_MSB:`DSS_CTRL_MODE_LSB] = s.stopMode;
    ctrlWord[`DSS_CTRL_HOLD]   = s.holdZero;
    ctrlWord[`DSS_CTRL_SWEN]   = s.swEnable;
    ctrlWord[`DSS_CTRL_CLOOP]  = s.closedLoop;
    ctrlWord[`DSS_CTRL_ORIENT] = s.posOrient;
    statWord = {16'h0000, 3'b000, s.orientActive, s.lockoutActive,
                s.driveReady, s.heldStop, s.dcInject, s.lowFreqInject,
                s.stopNoRamp, s.rampDown, s.inverterEnable, 4'(s.st)};

    // Divider giving a one-cycle tenth-second enable
    next_s.tick = tickHit ? 32'h0 : s.tick + 32'h1;
    if (tickHit && !timerDone) begin
      next_s.timer = s.timer - 8'h01;
    end

    // APB slave: data and answer loaded in setup, zero wait states
    next_s.pready  = setup;
    next_s.pslverr = setup & ~addrHit(paddr);
    if (setup) begin
      unique case (paddr)
        `DSS_ADDR_CTRL:   next_s.prdata = ctrlWord;
        `DSS_ADDR_LEVEL:  next_s.prdata = {21'h0, s.injLevel};
        `DSS_ADDR_TIME:   next_s.prdata = {24'h0, s.injTime};
        `DSS_ADDR_STATUS: next_s.prdata = statWord;
        default:          next_s.prdata = 32'h0;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        `DSS_ADDR_CTRL: begin
          next_s.stopMode = pwdata[`DSS_CTRL_MODE_MSB:`DSS_CTRL_MODE_LSB];
          next_s.holdZero   = pwdata[`DSS_CTRL_HOLD];
          next_s.swEnable   = pwdata[`DSS_CTRL_SWEN];
          next_s.closedLoop = pwdata[`DSS_CTRL_CLOOP];
          next_s.posOrient  = pwdata[`DSS_CTRL_ORIENT];
        end
        `DSS_ADDR_LEVEL: begin
          next_s.injLevel = (pwdata > 32'(`DSS_LEVEL_MAX)) ?
                            `DSS_LEVEL_MAX : pwdata[10:0];
        end
        `DSS_ADDR_TIME: begin
          next_s.injTime = (pwdata > 32'(`DSS_TIME_MAX)) ?
                           `DSS_TIME_MAX : pwdata[7:0];
        end
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Stop sequence

    next_s.enSeen = enabled;
    if (tripActive) begin
      next_s.st = DSS_READY;
    end else if (s.enSeen && !enabled) begin
      next_s.st    = DSS_LOCKOUT;
      next_s.timer = `DSS_LOCK_TICKS;
    end else begin
      unique case (s.st)
        DSS_READY, DSS_HELD: begin
          if (runCmd && enabled) begin
            next_s.st = DSS_RUN;
          end
        end
        DSS_RUN: begin
          if (!runCmd) begin
            if (s.posOrient) begin
              next_s.st = DSS_ORIENT;
            end else if (s.closedLoop) begin
              unique case (s.stopMode)
                `DSS_MODE_COAST:  next_s.st = DSS_READY;
                `DSS_MODE_RAMPDC: next_s.st = DSS_NO_RAMP;
                default:          next_s.st = DSS_RAMP_DOWN;
              endcase
            end else begin
              unique case (s.stopMode)
                `DSS_MODE_COAST: begin
                  next_s.st    = DSS_LOCKOUT;
                  next_s.timer = `DSS_LOCK_TICKS;
                end
                `DSS_MODE_LFDC: next_s.st = DSS_LF_INJ;
                `DSS_MODE_TIMEDC: begin
                  next_s.st    = DSS_DC_INJ;
                  next_s.timer = s.injTime;
                end
                `DSS_MODE_DISABLE: next_s.st = DSS_READY;
                default: next_s.st = DSS_RAMP_DOWN;
              endcase
            end
          end
        end
        DSS_RAMP_DOWN: begin
          if (runCmd) begin
            next_s.st = DSS_RUN;
          end else if (zeroFrequency) begin
            if (s.closedLoop) begin
              next_s.st = doneSt;
            end else if (s.stopMode == `DSS_MODE_RAMPDC) begin
              next_s.st    = DSS_DC_INJ;
              next_s.timer = s.injTime;
            end else begin
              next_s.st    = DSS_RAMP_HOLD;
              next_s.timer = `DSS_LOCK_TICKS;
            end
          end
        end
        DSS_RAMP_HOLD: begin
          if (timerDone) begin
            next_s.st = doneSt;
          end
        end
        DSS_LF_INJ: begin
          if (lowSpeedSensed) begin
            next_s.st    = DSS_DC_INJ;
            next_s.timer = s.injTime;
          end
        end
        DSS_DC_INJ: begin
          if (timerDone) begin
            next_s.st = doneSt;
          end
        end
        DSS_NO_RAMP: begin
          if (standstill) begin
            next_s.st = doneSt;
          end
        end
        DSS_ORIENT: begin
          if (orientDone) begin
            next_s.st = doneSt;
          end
        end
        DSS_LOCKOUT: begin
          if (timerDone) begin
            next_s.st = DSS_READY;
          end
        end
      endcase
    end

    // Restart the divider on entry so timed phases last whole ticks
    if (next_s.st != s.st || (s.enSeen && !enabled)) begin
      next_s.tick = 32'h0;
    end

    // Registered outputs follow the coming state
    next_s.inverterEnable = invOn(next_s.st);
    next_s.rampDown      = (next_s.st == DSS_RAMP_DOWN);
    next_s.stopNoRamp    = (next_s.st == DSS_NO_RAMP);
    next_s.lowFreqInject = (next_s.st == DSS_LF_INJ);
    next_s.dcInject      = (next_s.st == DSS_DC_INJ);
    next_s.heldStop      = (next_s.st == DSS_HELD);
    next_s.driveReady    = (next_s.st == DSS_READY);
    next_s.lockoutActive = (next_s.st == DSS_LOCKOUT);
    next_s.orientActive  = (next_s.st == DSS_ORIENT);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= RESET_S;
    end else begin
      s <= next_s;
    end
  end

  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign inverterEnable = s.inverterEnable;
  assign rampDown       = s.rampDown;
  assign stopNoRamp     = s.stopNoRamp;
  assign lowFreqInject  = s.lowFreqInject;
  assign dcInject       = s.dcInject;
  assign injectionLevel = s.injLevel;
  assign heldStop       = s.heldStop;
  assign driveReady     = s.driveReady;
  assign lockoutActive  = s.lockoutActive;
  assign orientActive   = s.orientActive;

endmodule : dss_stop_sequencer

// file: design/dss_defines.svh
// Offsets, fields, reset values and timing of the stop sequencer
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

`define DSS_ADDR_CTRL    12'h000
`define DSS_ADDR_LEVEL   12'h004
`define DSS_ADDR_TIME    12'h008
`define DSS_ADDR_STATUS  12'h00c

`define DSS_CTRL_MODE_LSB 0
`define DSS_CTRL_MODE_MSB 2
`define DSS_CTRL_HOLD     3
`define DSS_CTRL_SWEN     4
`define DSS_CTRL_CLOOP    5
`define DSS_CTRL_ORIENT   6

`define DSS_MODE_COAST   3'h0
`define DSS_MODE_RAMP    3'h1
`define DSS_MODE_RAMPDC  3'h2
`define DSS_MODE_LFDC    3'h3
`define DSS_MODE_TIMEDC  3'h4
`define DSS_MODE_DISABLE 3'h5

`define DSS_MODE_RST     3'h1
`define DSS_SWEN_RST     1'b1
`define DSS_LEVEL_RST    11'h3e8
`define DSS_LEVEL_MAX    11'h5dc
`define DSS_TIME_RST     8'h0a
`define DSS_TIME_MAX     8'hfa

`define DSS_CLK_FREQ_HZ  100000000
`define DSS_TICK_TIME_MS 100
`define DSS_LOCK_TIME_MS 1000
`define DSS_TICK_CYCLES  ((`DSS_CLK_FREQ_HZ / 1000) * `DSS_TICK_TIME_MS)
`define DSS_LOCK_TICKS   8'(`DSS_LOCK_TIME_MS / `DSS_TICK_TIME_MS)

`endif

// file: design/dss_pkg.sv
// Types of the stop sequencer
package dss_pkg;

  typedef enum logic [3:0] {
    DSS_READY,
    DSS_RUN,
    DSS_RAMP_DOWN,
    DSS_RAMP_HOLD,
    DSS_LF_INJ,
    DSS_DC_INJ,
    DSS_NO_RAMP,
    DSS_ORIENT,
    DSS_HELD,
    DSS_LOCKOUT
  } dss_state_e;

  typedef struct packed {
    dss_state_e  st;
    logic [31:0] tick;
    logic [7:0]  timer;
    logic        enSeen;
    logic [2:0]  stopMode;
    logic        holdZero;
    logic        swEnable;
    logic        closedLoop;
    logic        posOrient;
    logic [10:0] injLevel;
    logic [7:0]  injTime;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        inverterEnable;
    logic        rampDown;
    logic        stopNoRamp;
    logic        lowFreqInject;
    logic        dcInject;
    logic        heldStop;
    logic        driveReady;
    logic        lockoutActive;
    logic        orientActive;
  } dss_regs_s;

endpackage : dss_pkg

// file: sim/dss_motor_model.sv
// Behavioural motor and load answering the stop sequencer
`timescale 1ns/100ps
module dss_motor_model (
  input  wire logic        clk,
  input  wire logic        rampDown,
  input  wire logic        stopNoRamp,
  input  wire logic        lowFreqInject,
  input  wire logic        orientActive,
  input  wire logic [10:0] injectionLevel,
  input  wire logic [7:0]  lag,
  output logic             zeroFrequency,
  output logic             lowSpeedSensed,
  output logic             standstill,
  output logic             orientDone
);
  logic [7:0] age;
  wire logic busy = rampDown | stopNoRamp | lowFreqInject | orientActive;
  wire logic due = busy && age >= lag;
  // Age of the current slow-down, held at its ceiling
  always_ff @(posedge clk) begin
    age <= !busy ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
  end
  assign zeroFrequency = due && rampDown;
  assign standstill = due && stopNoRamp;
  // Weak injection never slows the rotor enough to be sensed
  assign lowSpeedSensed = due && lowFreqInject &&
    injectionLevel >= 11'h1f4;
  assign orientDone = due && orientActive;
endmodule : dss_motor_model

// file: sim/dss_stop_sequencer_props.sv
// Port-level checker for the stop sequencer
`timescale 1ns/100ps
module dss_stop_sequencer_props #(
  parameter int unsigned TICK_CYCLES = 10000000
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        runCmd,
  input wire logic        hwEnable,
  input wire logic        tripActive,
  input wire logic        zeroFrequency,
  input wire logic        lowSpeedSensed,
  input wire logic        standstill,
  input wire logic        orientDone,
  input wire logic        inverterEnable,
  input wire logic        rampDown,
  input wire logic        stopNoRamp,
  input wire logic        lowFreqInject,
  input wire logic        dcInject,
  input wire logic        heldStop,
  input wire logic        driveReady,
  input wire logic        lockoutActive,
  input wire logic        orientActive,
  input wire logic [10:0] injectionLevel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] lockCnt;
  always_ff @(posedge clk) begin
    lockCnt <= (!rst_n || !lockoutActive) ? 32'h0 : lockCnt + 32'h1;
  end
  property p_lock_time;
    $fell(lockoutActive) && !$past(tripActive) |->
      lockCnt >= 10 * TICK_CYCLES - 1 && lockCnt <= 12 * TICK_CYCLES;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lockout span");
  property p_hw_fall; $fell(hwEnable) && !tripActive |=> lockoutActive;
  endproperty
  a_hw_fall: assert property (p_hw_fall) else $error("no lockout");
  property p_inj_lock; lowFreqInject || dcInject |=>
    lowFreqInject || dcInject || heldStop || !inverterEnable; endproperty
  a_inj_lock: assert property (p_inj_lock) else $error("early run");
  property p_lf_dc; lowFreqInject && lowSpeedSensed && hwEnable &&
    !tripActive |=> dcInject; endproperty
  a_lf_dc: assert property (p_lf_dc) else $error("no dc phase");
  property p_held; heldStop |-> inverterEnable && !driveReady; endproperty
  a_held: assert property (p_held) else $error("held idle");
  property p_noramp; stopNoRamp && standstill && !tripActive |=>
    driveReady || heldStop || lockoutActive; endproperty
  a_noramp: assert property (p_noramp) else $error("no ready");
  property p_orient; orientActive && orientDone && !tripActive |=>
    driveReady || heldStop || lockoutActive; endproperty
  a_orient: assert property (p_orient) else $error("orient end");
  property p_stop_start;
    $fell(runCmd) && inverterEnable && !rampDown && !stopNoRamp &&
      !heldStop && !tripActive && hwEnable |=> !inverterEnable ||
      rampDown || stopNoRamp || lowFreqInject || dcInject || orientActive;
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("no stop");
  c_lf_dc: cover property (lowFreqInject ##1 dcInject);
  c_held: cover property (heldStop);
  c_lock: cover property ($fell(lockoutActive));
endmodule : dss_stop_sequencer_props
bind dss_stop_sequencer dss_stop_sequencer_props #(
  .TICK_CYCLES(TICK_CYCLES)
) u_props (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .runCmd(runCmd),
  .hwEnable(hwEnable), .tripActive(tripActive),
  .zeroFrequency(zeroFrequency), .lowSpeedSensed(lowSpeedSensed),
  .standstill(standstill), .orientDone(orientDone),
  .inverterEnable(inverterEnable), .rampDown(rampDown),
  .stopNoRamp(stopNoRamp), .lowFreqInject(lowFreqInject),
  .dcInject(dcInject), .heldStop(heldStop), .driveReady(driveReady),
  .lockoutActive(lockoutActive), .orientActive(orientActive),
  .injectionLevel(injectionLevel)
);

// file: sim/tb.sv
// Self-checking bench for the stop sequencer
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] CTL [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h15, 8'h30, 8'h31, 8'h32, 8'h70};
  localparam logic [6:0] EXP [10] = '{7'h20, 7'h03, 7'h13, 7'h19, 7'h11,
    7'h00, 7'h00, 7'h03, 7'h05, 7'h40};
  localparam int MN [10] = '{98, 98, 18, 18, 18, 0, 0, 0, 0, 0};
  localparam int MX [10] = '{125, 140, 60, 60, 45, 3, 3, 30, 30, 40};
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic runCmd = 0, hwEnable = 1, tripActive = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, zeroFrequency, lowSpeedSensed, standstill;
  logic orientDone, inverterEnable, rampDown, stopNoRamp, lowFreqInject;
  logic dcInject, heldStop, driveReady, lockoutActive, orientActive;
  logic [10:0] injectionLevel;
  int fails = 0, comparisons = 0;
  wire logic [6:0] vec = {orientActive, lockoutActive, dcInject,
    lowFreqInject, stopNoRamp, rampDown, inverterEnable};
  always #5 clk = ~clk;
  dss_stop_sequencer #(.TICK_CYCLES(10)) DUT (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .runCmd,
    .hwEnable, .tripActive, .zeroFrequency, .lowSpeedSensed, .standstill,
    .orientDone, .inverterEnable, .rampDown, .stopNoRamp, .lowFreqInject,
    .dcInject, .injectionLevel, .heldStop, .driveReady, .lockoutActive,
    .orientActive);
  dss_motor_model motor (.clk, .rampDown, .stopNoRamp, .lowFreqInject,
    .orientActive, .injectionLevel, .lag(8'h05), .zeroFrequency,
    .lowSpeedSensed, .standstill, .orientDone);
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do @(posedge clk); while (pready !== 1 && ++n < 20);
    if (pready !== 1) chk("pready", 1, pready);
    rdat = prdata; rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk("register", e, rdat);
  endtask : rd
  task automatic run_wait;
    int n;
    runCmd <= 1;
    n = 0;
    do @(posedge clk); while (vec !== 7'h01 && ++n < 300);
  endtask : run_wait
  task automatic t_regs;
    rd(12'h000, 32'h11);
    rd(12'h004, 32'h3e8);
    rd(12'h008, 32'h0a);
    rd(12'h00c, 32'h400);
    apb(1, 12'h010, 32'hff);
    chk("slverr", 1, rerr);
    rd(12'h010, 32'h0);
    apb(1, 12'h004, 32'h7ff);
    rd(12'h004, 32'h5dc);
    apb(1, 12'h008, 32'hff);
    rd(12'h008, 32'hfa);
    apb(1, 12'h004, 32'h258);
    apb(1, 12'h008, 32'h2);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_modes;
    logic [6:0] seen, m;
    int n;
    for (int i = 0; i < 10; i++) begin
      apb(1, 12'h000, {24'h0, CTL[i]});
      run_wait();
      runCmd <= 0;
      repeat (2) @(posedge clk);
      chk("stop begins", 1, vec !== 7'h01);
      seen = vec;
      n = 0;
      while (driveReady !== 1 && n < 300) begin
        if (i == 4 && dcInject === 1) runCmd <= 1;
        if (dcInject === 1) chk("level", 32'h258, injectionLevel);
        @(posedge clk);
        seen |= vec;
        n++;
      end
      m = (i == 9) ? 7'h7c : 7'h7f;
      chk("phases", EXP[i] & m, seen & m);
      chk("stop time", 1, n >= MN[i] && n <= MX[i]);
      if (i == 5) begin
        runCmd <= 1;
        repeat (3) @(posedge clk);
        chk("restart", 1, inverterEnable);
      end
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_hold;
    int n;
    apb(1, 12'h000, 32'h19);
    run_wait();
    runCmd <= 0;
    n = 0;
    do @(posedge clk); while (heldStop !== 1 && ++n < 300);
    chk("held", 1, inverterEnable && !driveReady);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_lock(input logic sw);
    int n;
    apb(1, 12'h000, 32'h15);
    run_wait();
    if (sw) apb(1, 12'h000, 32'h05);
    else hwEnable <= 0;
    @(posedge clk);
    hwEnable <= 1;
    if (sw) apb(1, 12'h000, 32'h15);
    n = 0;
    do @(posedge clk); while (inverterEnable !== 1 && ++n < 300);
    chk("relock time", 1, n >= 90 && n <= 120);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_trip;
    int n;
    apb(1, 12'h000, 32'h14);
    run_wait();
    runCmd <= 0;
    n = 0;
    do @(posedge clk); while (dcInject !== 1 && ++n < 300);
    tripActive <= 1;
    @(posedge clk);
    tripActive <= 0;
    @(posedge clk);
    chk("trip ready", 1, driveReady);
    chk("trip inject", 0, dcInject);
    runCmd <= 1;
    repeat (2) @(posedge clk);
    chk("trip restart", 1, inverterEnable);
    $display("t_trip done");
  endtask : t_trip
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_modes();
    t_hold();
    t_trip();
    t_lock(0);
    t_lock(1);
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : tb
